/* File: hdl/pdc_regs.sv */
// Port direction and command registers with soft return-from-interrupt
// ------------------------------------------------------------------------
// ------------------------------------------------------------------------
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps

module pdc_regs
  import pdc_pkg::*;
#(
  parameter int NUM_UNITS = PDC_NUM_UNITS,
  parameter int PORT_W    = 8
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Register port
  input  wire logic [3:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr_stb,
  input  wire logic                 rd_stb,
  output      logic [7:0]           rdata,
  // General port pins
  input  wire logic [PORT_W-1:0]    general_port_in,
  output      logic [PORT_W-1:0]    general_port_out,
  output      logic [PORT_W-1:0]    general_port_oe_n,
  // Sub-unit controls
  output      logic [NUM_UNITS-1:0] unit_reset,
  output      logic [2:0]           chain_priority,
  // Daisy chain
  input  wire logic                 chain_enable_in,
  input  wire logic [NUM_UNITS-1:0] unit_service_set,
  output      logic [NUM_UNITS-1:0] unit_under_service,
  output      logic                 chain_enable_out,
  output      logic                 soft_return_busy
);

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  logic [3:0]            lock_cnt_q;
  logic                  locked;
  logic                  wr_ok;
  logic                  rd_ok;
  logic                  soft_ret_go;
  logic [NUM_UNITS-1:0]  top_unit;
  logic [NUM_UNITS-1:0]  svc_d;

  // Lockout window drops any access, reads and writes alike
  assign locked      = (lock_cnt_q != 4'h0);
  assign wr_ok       = wr_stb && !locked;
  assign rd_ok       = rd_stb && !locked;
  // Only D0 matters; upper bits are don't-care by software contract
  assign soft_ret_go = wr_ok && (addr == PDC_ADDR_SOFT_RET)
                       && wdata[PDC_SOFT_RET_BIT];

  // ----------------------------------------------------------------------
  // Port direction and output data
  // ----------------------------------------------------------------------
  logic [PORT_W-1:0] port_dir_q;
  logic [PORT_W-1:0] port_out_q;

  // Direction register, 1 means input; reset leaves all pins as inputs
  always_ff @(posedge clock) begin
    if (rst) begin
      port_dir_q <= PORT_W'(PDC_PORT_DIR_RST);
    end else if (wr_ok && addr == PDC_ADDR_PORT_DIR) begin
      port_dir_q <= wdata[PORT_W-1:0];
    end
  end

  // Output latch for pins set as outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      port_out_q <= PORT_W'(PDC_PORT_OUT_RST);
    end else if (wr_ok && addr == PDC_ADDR_PORT_DATA) begin
      port_out_q <= wdata[PORT_W-1:0];
    end
  end

  // Pin drivers registered; enable low drives the pin
  always_ff @(posedge clock) begin
    if (rst) begin
      general_port_oe_n <= PORT_W'(PDC_PORT_DIR_RST);
      general_port_out  <= PORT_W'(PDC_PORT_OUT_RST);
    end else begin
      general_port_oe_n <= (wr_ok && addr == PDC_ADDR_PORT_DIR) ?
                           wdata[PORT_W-1:0] : port_dir_q;
      general_port_out  <= (wr_ok && addr == PDC_ADDR_PORT_DATA) ?
                           wdata[PORT_W-1:0] : port_out_q;
    end
  end

  // ----------------------------------------------------------------------
  // First command register
  // ----------------------------------------------------------------------
  // Reset bits are not stored: a write gives exactly one pulse cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      unit_reset <= '0;
    end else if (wr_ok && addr == PDC_ADDR_CMD_A) begin
      unit_reset <= wdata[PDC_CMDA_RST_LSB +: NUM_UNITS];
    end else begin
      unit_reset <= '0;
    end
  end

  // Priority field is held until rewritten
  always_ff @(posedge clock) begin
    if (rst) begin
      chain_priority <= PDC_PRIO_RST;
    end else if (wr_ok && addr == PDC_ADDR_CMD_A) begin
      chain_priority <= wdata[PDC_CMDA_PRIO_LSB +: PDC_PRIO_W];
    end
  end

  // ----------------------------------------------------------------------
  // Soft return sequence and lockout
  // ----------------------------------------------------------------------
  // Counter loads on a D0=1 write and counts the 8 recovery cycles
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_cnt_q <= 4'h0;
    end else if (soft_ret_go) begin
      lock_cnt_q <= PDC_RECOVERY_CNT;
    end else if (locked) begin
      lock_cnt_q <= lock_cnt_q - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      soft_return_busy <= 1'b0;
    end else begin
      soft_return_busy <= soft_ret_go || (lock_cnt_q > 4'h1);
    end
  end

  // Lowest index is highest priority; isolate lowest set bit
  assign top_unit = unit_under_service
                    & (~unit_under_service + NUM_UNITS'(1));

  // Service state: the soft return forces enable high internally, so the
  // top unit is cleared regardless of the pin; a new set wins the cycle
  always_comb begin
    svc_d = unit_under_service;
    if (soft_ret_go) begin
      svc_d = svc_d & ~top_unit;
    end
    svc_d = svc_d | unit_service_set;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      unit_under_service <= '0;
    end else begin
      unit_under_service <= svc_d;
    end
  end

  // Enable to lower chain: pin state, forced high in the sequence, passed only while no unit is under service
  always_ff @(posedge clock) begin
    if (rst) begin
      chain_enable_out <= 1'b0;
    end else begin
      chain_enable_out <= (chain_enable_in || soft_ret_go)
                          && (svc_d == '0);
    end
  end

  // ----------------------------------------------------------------------
  // Read path: data one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_ok) begin
      case (addr)
        PDC_ADDR_PORT_DATA: rdata <= 8'(general_port_in);
        PDC_ADDR_STATUS:    rdata <= 8'({chain_priority,
                                         unit_under_service});
        PDC_ADDR_SOFT_RET:  rdata <= 8'h00;
        default:            rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_reset_inputs;
    @(posedge clock) $past(rst) |-> general_port_oe_n == '1;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("port not all inputs after reset");

  property p_dir_follow;
    @(posedge clock) disable iff (rst)
      (wr_ok && addr == PDC_ADDR_PORT_DIR) |=>
        general_port_oe_n == $past(wdata[PORT_W-1:0]);
  endproperty
  a_dir_follow: assert property (p_dir_follow)
    else $error("direction not applied");

  property p_reset_pulse;
    @(posedge clock) disable iff (rst)
      !(wr_ok && addr == PDC_ADDR_CMD_A) |=>
        unit_reset == '0;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("unit reset not a single pulse");

  property p_prio_load;
    @(posedge clock) disable iff (rst)
      (wr_ok && addr == PDC_ADDR_CMD_A) |=>
        chain_priority == $past(wdata[PDC_CMDA_PRIO_LSB +: PDC_PRIO_W]);
  endproperty
  a_prio_load: assert property (p_prio_load)
    else $error("priority not loaded");

  property p_lock_len;
    @(posedge clock) disable iff (rst)
      soft_ret_go |=> locked [*8] ##1 !locked;
  endproperty
  a_lock_len: assert property (p_lock_len)
    else $error("recovery window not 8 cycles");

  property p_ignore_write;
    @(posedge clock) disable iff (rst)
      (locked && wr_stb && addr == PDC_ADDR_PORT_DIR) |=>
        $stable(port_dir_q);
  endproperty
  a_ignore_write: assert property (p_ignore_write)
    else $error("write taken during recovery");

  property p_zero_noop;
    @(posedge clock) disable iff (rst)
      (wr_stb && !locked && addr == PDC_ADDR_SOFT_RET && !wdata[0]) |=>
        !locked && $stable(port_dir_q);
  endproperty
  a_zero_noop: assert property (p_zero_noop)
    else $error("zero write had an effect");

  property p_clear_top;
    @(posedge clock) disable iff (rst)
      (soft_ret_go && unit_under_service[0] && !unit_service_set[0])
        |=> !unit_under_service[0];
  endproperty
  a_clear_top: assert property (p_clear_top)
    else $error("top unit not cleared");

  property p_forced_high;
    @(posedge clock) disable iff (rst)
      (soft_ret_go && !chain_enable_in && svc_d == '0)
        |=> chain_enable_out;
  endproperty
  a_forced_high: assert property (p_forced_high)
    else $error("chain enable not forced high");

  // Register load and hold checks
  property p_reset_load;
    @(posedge clock) disable iff (rst)
      (wr_ok && addr == PDC_ADDR_CMD_A) |=>
        unit_reset == $past(wdata[PDC_CMDA_RST_LSB +: NUM_UNITS]);
  endproperty
  a_reset_load: assert property (p_reset_load)
    else $error("unit reset bits not pulsed");

  property p_prio_hold;
    @(posedge clock) disable iff (rst)
      !(wr_ok && addr == PDC_ADDR_CMD_A) |=> $stable(chain_priority);
  endproperty
  a_prio_hold: assert property (p_prio_hold)
    else $error("priority changed without a write");

  property p_dir_hold;
    @(posedge clock) disable iff (rst)
      !(wr_ok && addr == PDC_ADDR_PORT_DIR) |=> $stable(general_port_oe_n);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction changed without a write");

  property p_out_load;
    @(posedge clock) disable iff (rst)
      (wr_ok && addr == PDC_ADDR_PORT_DATA) |=>
        general_port_out == $past(wdata[PORT_W-1:0]);
  endproperty
  a_out_load: assert property (p_out_load)
    else $error("port output data not applied");

  // Lockout and read path checks
  property p_busy_match;
    @(posedge clock) disable iff (rst)
      soft_return_busy == locked;
  endproperty
  a_busy_match: assert property (p_busy_match)
    else $error("busy flag out of step with lockout");

  property p_read_drop;
    @(posedge clock) disable iff (rst)
      (locked && rd_stb) |=> rdata == 8'h00;
  endproperty
  a_read_drop: assert property (p_read_drop)
    else $error("read answered during recovery");

  property p_soft_ret_read;
    @(posedge clock) disable iff (rst)
      (rd_ok && addr == PDC_ADDR_SOFT_RET) |=> rdata == 8'h00;
  endproperty
  a_soft_ret_read: assert property (p_soft_ret_read)
    else $error("second command register read not zero");

  // Chain checks; a new service mark must never be lost
  property p_enable_follow;
    @(posedge clock) disable iff (rst)
      !soft_ret_go |=> chain_enable_out ==
        ($past(chain_enable_in) && (unit_under_service == '0));
  endproperty
  a_enable_follow: assert property (p_enable_follow)
    else $error("chain enable does not follow input");

  property p_set_wins;
    @(posedge clock) disable iff (rst)
      (unit_service_set != '0) |=>
        (unit_under_service & $past(unit_service_set))
          == $past(unit_service_set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("service mark lost");

  c_soft_ret: cover property (@(posedge clock) soft_ret_go);
  c_lock_hit: cover property (@(posedge clock) locked && wr_stb);
  c_unit_rst: cover property (@(posedge clock) unit_reset != '0);
  c_dir_mix:  cover property (@(posedge clock)
                (general_port_oe_n != '0) && (general_port_oe_n != '1));
  c_chain_free: cover property (@(posedge clock)
                soft_ret_go && !chain_enable_in && svc_d == '0);

endmodule : pdc_regs

/* File: include/pdc_pkg.sv */
// Package: register map, field layout and timing for the port/command block
package pdc_pkg;

  // ----------------------------------------------------------------------
  // Register map (register index = byte address on this plain port)
  // ----------------------------------------------------------------------
  localparam logic [3:0] PDC_ADDR_PORT_DIR   = 4'h0; // port_direction
  localparam logic [3:0] PDC_ADDR_CMD_A      = 4'h1; // first command reg
  localparam logic [3:0] PDC_ADDR_PORT_DATA  = 4'h2; // port output/input
  localparam logic [3:0] PDC_ADDR_STATUS     = 4'h3; // block status
  localparam logic [3:0] PDC_ADDR_SOFT_RET   = 4'hf; // soft_return_command

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int PDC_NUM_UNITS      = 3;   // sub-units with soft reset
  localparam int PDC_CMDA_RST_LSB   = 0;   // reset bits [2:0]
  localparam int PDC_CMDA_PRIO_LSB  = 3;   // priority field [5:3]
  localparam int PDC_PRIO_W         = 3;
  localparam int PDC_SOFT_RET_BIT   = 0;   // D0 of soft_return_command

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PDC_PORT_DIR_RST  = 8'hff; // all inputs
  localparam logic [7:0] PDC_PORT_OUT_RST  = 8'h00;
  localparam logic [2:0] PDC_PRIO_RST      = 3'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int PDC_CLK_PERIOD_NS    = 10;
  localparam int PDC_RECOVERY_CYCLES  = 8;  // lockout after soft return
  localparam logic [3:0] PDC_RECOVERY_CNT = 4'(PDC_RECOVERY_CYCLES);

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pdc_req_s;

  typedef struct packed {
    logic [PDC_NUM_UNITS-1:0] unit_under_service;
  } pdc_chain_s;

endpackage : pdc_pkg

/* File: dv/pdc_host.sv */
// Host bus master model driving the register port
`timescale 1ns/100ps

module pdc_host
  import pdc_pkg::*;
(
  // Clock
  input  wire logic       clock,
  // Register port
  output      logic [3:0] addr,
  output      logic [7:0] wdata,
  output      logic       wr_stb,
  output      logic       rd_stb,
  input  wire logic [7:0] rdata
);
  // ----------------------------------------------------------------
  // Idle levels at time zero
  // ----------------------------------------------------------------
  initial begin
    addr   = 4'h0;
    wdata  = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // Released lines show the inverse so stale values are never trusted
  task automatic write(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == PDC_ADDR_SOFT_RET) begin
      v[7:1] = 7'h00;
    end
    @(posedge clock);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clock);
    addr   <= ~a;
    wdata  <= ~v;
    wr_stb <= 1'b0;
    #1;
  endtask : write

  // Read data is taken one cycle after the strobe, only there
  task automatic read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    addr   <= ~a;
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : read
endmodule : pdc_host

/* File: dv/pdc_regs_bench.sv */
// Self-checking bench for the port/command register block
`timescale 1ns/100ps

module pdc_regs_bench
  import pdc_pkg::*;
;
  logic       clock = 1'b0;
  logic       rst;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, port_in, port_out, oe_n;
  logic       wr_stb, rd_stb, en_in, en_out, busy;
  logic [2:0] unit_rst, prio, svc_set, svc;
  int         errors = 0;
  int         total_checks = 0;

  // ----------------------------------------------------------------
  // Clock, host model and design
  // ----------------------------------------------------------------
  always #(PDC_CLK_PERIOD_NS / 2) clock = ~clock;

  pdc_host pdc_host_inst (.clock(clock), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

  pdc_regs pdc_regs_inst (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .general_port_in(port_in), .general_port_out(port_out),
    .general_port_oe_n(oe_n), .unit_reset(unit_rst),
    .chain_priority(prio), .chain_enable_in(en_in),
    .unit_service_set(svc_set), .unit_under_service(svc),
    .chain_enable_out(en_out), .soft_return_busy(busy));

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Single exit point for the whole run
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // Watchdog at 5000 cycles, far beyond the fewer than 100 cycles the tests need
  initial begin
    #50000;
    errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] r;
    int         n;
    rst <= 1'b1;
    port_in <= 8'h96;
    en_in <= 1'b0; // Chain held off, soft return must still act
    svc_set <= 3'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(oe_n, 8'hff);
    // Each unit reset pulses once and the priority field loads 5 with each write
    for (int i = 0; i < PDC_NUM_UNITS; i++) begin
      pdc_host_inst.write(PDC_ADDR_CMD_A, 8'h28 | (8'h01 << i));
      chk({5'h00, unit_rst}, 8'h01 << i);
      chk({5'h00, prio}, 8'h05);
      @(posedge clock);
      #1;
      chk({5'h00, unit_rst}, 8'h00);
    end
    // Direction, port data and plain reads
    pdc_host_inst.write(PDC_ADDR_PORT_DIR, 8'h5a);
    chk(oe_n, 8'h5a);
    pdc_host_inst.write(PDC_ADDR_PORT_DATA, 8'hc3);
    chk(port_out, 8'hc3);
    pdc_host_inst.read(PDC_ADDR_PORT_DATA, r);
    chk(r, 8'h96);
    pdc_host_inst.read(4'h7, r);
    chk(r, 8'h00);
    // Put units 0 and 2 under service
    @(posedge clock);
    svc_set <= 3'h5;
    @(posedge clock);
    svc_set <= 3'h0;
    #1;
    chk({5'h00, svc}, 8'h05);
    pdc_host_inst.read(PDC_ADDR_STATUS, r);
    chk(r, 8'h2d);
    // A zero in D0 does nothing
    pdc_host_inst.write(PDC_ADDR_SOFT_RET, 8'hfe);
    chk({5'h00, svc}, 8'h05);
    chk({7'h00, busy}, 8'h00);
    // Soft return clears the top unit even with the chain held off
    pdc_host_inst.write(PDC_ADDR_SOFT_RET, 8'h01);
    chk({5'h00, svc}, 8'h04);
    chk({7'h00, busy}, 8'h01);
    chk({7'h00, en_out}, 8'h00);
    // Accesses inside the recovery span are dropped
    pdc_host_inst.write(PDC_ADDR_PORT_DIR, 8'h00);
    chk(oe_n, 8'h5a);
    pdc_host_inst.read(PDC_ADDR_PORT_DATA, r);
    chk(r, 8'h00);
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(8'(n), 8'h04);
    pdc_host_inst.write(PDC_ADDR_PORT_DIR, 8'h0f);
    chk(oe_n, 8'h0f);
    pdc_host_inst.read(PDC_ADDR_SOFT_RET, r);
    chk(r, 8'h00);
    // Clearing the last unit frees the chain for one cycle only
    pdc_host_inst.write(PDC_ADDR_SOFT_RET, 8'h01);
    chk({5'h00, svc}, 8'h00);
    chk({7'h00, en_out}, 8'h01);
    @(posedge clock);
    #1;
    chk({7'h00, en_out}, 8'h00);
    // Writes landing 3, 5 and 7 cycles in are dropped, at 9 taken
    for (int i = 0; i < 4; i++) begin
      pdc_host_inst.write(PDC_ADDR_PORT_DIR, 8'h30 + 8'(i));
      chk(oe_n, (i < 3) ? 8'h0f : 8'h33);
    end
    // Second reset in mid-run
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(oe_n, 8'hff);
    chk({5'h00, svc}, 8'h00);
    chk({5'h00, prio}, 8'h00);
    chk(port_out, 8'h00);
    chk({7'h00, busy}, 8'h00);
    // First write right after release is taken
    pdc_host_inst.write(PDC_ADDR_CMD_A, 8'h10);
    chk({5'h00, prio}, 8'h02);
    // Open chain passes the enable on while nothing is under service
    @(posedge clock);
    en_in <= 1'b1;
    @(posedge clock);
    #1;
    chk({7'h00, en_out}, 8'h01);
    test_done();
  end
endmodule : pdc_regs_bench
